// >>> ssio_core.sv
`default_nettype none
// How it works
// - order bit 0 shifts msb first, 1 shifts lsb first, both ways.
// - direction bit 0 receives only, 1 transmits and receives.
// - enable 0 stops shifter and counter; enable 1 runs and sets flag.
// - writing start clears the flag and bit counter, then begins a transfer.
// - start bit drops by itself once the transfer has begun.
// - mode bit 4 is unused and always reads back as zero.
// - mode register is write only, byte writes, start also bit writable.
// - code 001 clocks the shifter from the timer output.
// - codes 01x use the cpu clock divided by 4, 8 or 64.
// - code 100 uses the system clock divided by 1024.
// - code 111 uses the system clock divided by 16.
// - non cpu sources allow buffer access only when halted or clock high.
// - divide by 16 is not offered while the cpu clock is divided by 64.
// - transmit mode drives one buffer bit out on each falling clock edge.
// - transmit mode samples the input bit on each rising clock edge.
// - receive mode shifts in on rising edges and leaves output undriven.
// - after eight bits the flag sets and interrupts if enabled.
// - the buffer is an eight bit read write register, not reset.
// - code 000 takes the clock from the pin, driven by the far device.
module ssio_core #(
  parameter int unsigned FIFO_DEPTH = ssio_pkg::FIFO_DEPTH
) (
  input  wire logic                       clock,
  input  wire logic                       rst,
  input  wire logic [ssio_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [ssio_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_bit_wr,
  input  wire logic [1:0]                 reg_bit_sel,
  input  wire logic                       reg_bit_val,
  input  wire logic                       reg_rd,
  output logic      [ssio_pkg::DATA_W-1:0] reg_rdata,
  output logic                            reg_refused,
  input  wire logic [1:0]                 cpu_div_sel,
  input  wire logic                       timer_out_clock,
  input  wire logic                       sck_in,
  output logic                            sck_out,
  output logic                            sck_oe_n,
  input  wire logic                       si_in,
  output logic                            so_out,
  output logic                            so_oe_n,
  input  wire logic                       serial_irq_enable,
  input  wire logic                       irq_flag_clr,
  output logic                            serial_irq_flag,
  output logic                            serial_irq,
  output logic                            busy,
  output logic                            rx_valid,
  output logic      [ssio_pkg::DATA_W-1:0] rx_data,
  input  wire logic                       rx_ready
);
  import ssio_pkg::*;
  generate
    if (FIFO_DEPTH < 2)
    begin : g_bad
      $error("receive fifo needs at least two words");
    end
  endgenerate

  ssio_fifo_if #(.WIDTH(DATA_W)) rxq ();
  ssio_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clock (clock),
    .rst   (rst),
    .f     (rxq.fifo)
  );

  logic [7:0]       serial_mode_reg;
  logic [7:0]       serial_shift_buffer;
  ssio_state_e      state_reg;
  logic [2:0]       bit_cnt_reg;
  logic [HALF_W-1:0] half_cnt_reg;
  logic             gen_reg;
  logic             sck_prev_reg;
  logic [2:0]       sck_sync_reg;
  logic             sck_lvl_reg;
  logic [2:0]       si_sync_reg;
  logic             si_lvl_reg;
  logic             so_reg;
  logic             flag_reg;
  logic             tmr_open_reg;
  ssio_src_e        src;
  logic             sck_now;
  logic             rise_evt;
  logic             fall_evt;
  logic             running;
  logic             done;
  logic             start_take;
  logic             buf_open;
  logic             buf_wr;
  logic             buf_rd;
  logic             mode_wr;
  logic             start_bit_wr;
  logic [HALF_W-1:0] half_len;

  function automatic ssio_src_e pick_src(input logic [2:0] csel,
                                         input logic [1:0] div);
    ssio_src_e s;
    s = SSIO_SRC_NONE;
    if (csel == CSEL_EXT) s = SSIO_SRC_EXT;
    else if (csel == CSEL_TIMER) s = SSIO_SRC_TIMER;
    else if (csel[2:1] == CSEL_CPU_TOP) s = SSIO_SRC_CPU;
    else if (csel == CSEL_SLOW) s = SSIO_SRC_SLOW;
    else if (csel == CSEL_FAST && div != CPU_DIV64)
      s = SSIO_SRC_FAST;
    return s;
  endfunction : pick_src

  function automatic logic [HALF_W-1:0] half_of(input ssio_src_e s,
                                                input logic [1:0] div);
    logic [HALF_W-1:0] h;
    h = HALF_FAST;
    if (s == SSIO_SRC_SLOW) h = HALF_SLOW;
    else if (s == SSIO_SRC_CPU && div == CPU_DIV4) h = HALF_DIV4;
    else if (s == SSIO_SRC_CPU && div == CPU_DIV8) h = HALF_DIV8;
    else if (s == SSIO_SRC_CPU) h = HALF_DIV64;
    return h;
  endfunction : half_of

  // next outgoing bit and the buffer after one shift
  function automatic logic head_bit(input logic [7:0] b, input logic lsb);
    return lsb ? b[0] : b[7];
  endfunction : head_bit

  function automatic logic [7:0] shift_in(input logic [7:0] b,
                                          input logic si,
                                          input logic lsb);
    return lsb ? {si, b[7:1]} : {b[6:0], si};
  endfunction : shift_in

  assign src      = pick_src(serial_mode_reg[7:CSEL_LSB], cpu_div_sel);
  assign half_len = half_of(src, cpu_div_sel);
  always_comb
  begin
    case (src)
      SSIO_SRC_EXT:   sck_now = sck_lvl_reg;
      SSIO_SRC_TIMER: sck_now = tmr_open_reg ? timer_out_clock : 1'b1;
      SSIO_SRC_NONE:  sck_now = 1'b1;
      default:        sck_now = gen_reg;
    endcase
  end
  assign running  = (state_reg == SSIO_RUN) && serial_mode_reg[ENABLE_BIT];
  assign rise_evt = running && sck_now && !sck_prev_reg;
  assign fall_evt = running && !sck_now && sck_prev_reg;
  assign done     = rise_evt && (bit_cnt_reg == LAST_BIT);
  // a transfer waits for room to store its received byte
  assign start_take = serial_mode_reg[START_BIT] &&
                      (rxq.in_ready || !serial_mode_reg[ENABLE_BIT]);
  assign buf_open = ((state_reg == SSIO_IDLE) || sck_now ||
                     (src == SSIO_SRC_CPU)) && !rise_evt;
  assign mode_wr  = reg_wr && (reg_addr == MODE_LO_ADDR);
  assign start_bit_wr = reg_bit_wr && (reg_addr == MODE_LO_ADDR) &&
                        (reg_bit_sel == START_SEL) && reg_bit_val;
  assign buf_wr   = reg_wr && (reg_addr == BUF_ADDR) && buf_open;
  assign buf_rd   = reg_rd && (reg_addr == BUF_ADDR) && buf_open;

  assign rxq.in_valid  = done;
  assign rxq.in_data   = shift_in(serial_shift_buffer, si_lvl_reg,
                                  serial_mode_reg[ORDER_BIT]);
  assign rxq.out_ready = rx_ready;
  assign rx_valid      = rxq.out_valid;
  assign rx_data       = rxq.out_data;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sck_sync_reg <= 3'h7;
      sck_lvl_reg  <= 1'b1;
      si_sync_reg  <= 3'h0;
      si_lvl_reg   <= 1'b0;
    end
    else
    begin
      sck_sync_reg <= {sck_sync_reg[1:0], sck_in};
      si_sync_reg  <= {si_sync_reg[1:0], si_in};
      if (sck_sync_reg[1] == sck_sync_reg[2])
      begin
        sck_lvl_reg <= sck_sync_reg[2];
      end
      if (si_sync_reg[1] == si_sync_reg[2])
      begin
        si_lvl_reg <= si_sync_reg[2];
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      serial_mode_reg <= MODE_RESET;
    end
    else if (mode_wr)
    begin
      serial_mode_reg <= reg_wdata & ~(8'h01 << UNUSED_BIT);
    end
    else if (start_bit_wr)
    begin
      serial_mode_reg[START_BIT] <= 1'b1;
    end
    else if (start_take)
    begin
      serial_mode_reg[START_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_reg   <= SSIO_IDLE;
      bit_cnt_reg <= 3'h0;
    end
    else if (start_take)
    begin
      bit_cnt_reg <= 3'h0;
      state_reg   <= serial_mode_reg[ENABLE_BIT] ? SSIO_RUN
                                                 : SSIO_IDLE;
    end
    else
    begin
      case (state_reg)
        SSIO_RUN:
        begin
          if (done)
          begin
            state_reg <= SSIO_IDLE;
          end
          if (rise_evt)
          begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
          end
        end
        default:
        begin
          state_reg <= SSIO_IDLE;
        end
      endcase
    end
  end

  // timer clock passes only from a high phase on, so that a transfer
  // never opens with a cut-short low period
  always_ff @(posedge clock)
  begin
    if (rst || !busy)
    begin
      tmr_open_reg <= 1'b0;
    end
    else if (timer_out_clock)
    begin
      tmr_open_reg <= 1'b1;
    end
  end

  // internal serial clock: idles high, one toggle per half period
  always_ff @(posedge clock)
  begin
    if (rst || start_take || !running)
    begin
      half_cnt_reg <= '0;
      gen_reg      <= running ? gen_reg : 1'b1;
    end
    else if (half_cnt_reg >= half_len - HALF_W'(1))
    begin
      half_cnt_reg <= '0;
      gen_reg      <= ~gen_reg;
    end
    else
    begin
      half_cnt_reg <= half_cnt_reg + HALF_W'(1);
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sck_prev_reg <= 1'b1;
    end
    else
    begin
      sck_prev_reg <= sck_now;
    end
  end

  // no reset: buffer content is undefined after reset
  always_ff @(posedge clock)
  begin
    if (rise_evt)
    begin
      serial_shift_buffer <= rxq.in_data;
    end
    else if (buf_wr)
    begin
      serial_shift_buffer <= reg_wdata;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      so_reg <= 1'b1;
    end
    else if (fall_evt && serial_mode_reg[DIR_BIT])
    begin
      so_reg <= head_bit(serial_shift_buffer,
                         serial_mode_reg[ORDER_BIT]);
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      flag_reg <= 1'b0;
    end
    else if (done)
    begin
      flag_reg <= 1'b1;
    end
    else if (start_take || irq_flag_clr)
    begin
      flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      reg_rdata   <= 8'h00;
      reg_refused <= 1'b0;
    end
    else
    begin
      reg_refused <= (reg_wr || reg_rd) && (reg_addr == BUF_ADDR) &&
                     !buf_open ||
                     reg_wr && (reg_addr == MODE_HI_ADDR);
      if (buf_rd)
      begin
        reg_rdata <= serial_shift_buffer;
      end
      else if (reg_rd)
      begin
        reg_rdata <= 8'h00;
      end
    end
  end

  assign busy            = (state_reg == SSIO_RUN);
  assign serial_irq_flag = flag_reg;
  assign serial_irq      = flag_reg && serial_irq_enable;
  assign sck_out  = (src == SSIO_SRC_TIMER) ? sck_now : gen_reg;
  assign sck_oe_n = (src == SSIO_SRC_EXT);
  assign so_out   = so_reg;
  assign so_oe_n  = !serial_mode_reg[DIR_BIT];

  logic [4:0] rise_seen_reg;
  always_ff @(posedge clock)
  begin
    if (rst || start_take)
      rise_seen_reg <= 5'h00;
    else if (rise_evt)
      rise_seen_reg <= rise_seen_reg + 5'h01;
  end

  sequence s_begin;
    start_take && serial_mode_reg[ENABLE_BIT] ##1 busy;
  endsequence
  sequence s_cleared;
    !flag_reg && bit_cnt_reg == 3'h0;
  endsequence

  a_start_clears: assert property (@(posedge clock) disable iff (rst)
    start_take && !done |=> s_cleared)
  else $error("start did not clear flag and counter");
  a_start_drops: assert property (@(posedge clock) disable iff (rst)
    s_begin |-> !serial_mode_reg[START_BIT] || $past(start_bit_wr))
  else $error("start bit stayed set after transfer began");
  a_unused_zero: assert property (@(posedge clock) disable iff (rst)
    serial_mode_reg[UNUSED_BIT] == 1'b0)
  else $error("unused mode bit set");
  a_done_flag: assert property (@(posedge clock) disable iff (rst)
    done |=> flag_reg && !busy)
  else $error("flag not set at end of transfer");
  a_eight_rises: assert property (@(posedge clock) disable iff (rst)
    $fell(busy) |-> rise_seen_reg == 5'h08 || $past(start_take))
  else $error("transfer did not span eight clocks");
  a_idle_high: assert property (@(posedge clock) disable iff (rst)
    !busy && src != SSIO_SRC_EXT && src != SSIO_SRC_TIMER |-> sck_out)
  else $error("internal serial clock not high at idle");
  a_rx_undriven: assert property (@(posedge clock) disable iff (rst)
    !serial_mode_reg[DIR_BIT] |-> so_oe_n)
  else $error("output driven in receive mode");
  a_fast_block: assert property (@(posedge clock) disable iff (rst)
    serial_mode_reg[7:CSEL_LSB] == CSEL_FAST && cpu_div_sel == CPU_DIV64
    |-> !rise_evt && !fall_evt)
  else $error("fast clock used with slow cpu clock");
  a_out_bit: assert property (@(posedge clock) disable iff (rst)
    fall_evt && serial_mode_reg[DIR_BIT] |=>
    so_out == $past(head_bit(serial_shift_buffer,
                             serial_mode_reg[ORDER_BIT])))
  else $error("wrong bit driven on falling edge");
  a_buf_closed: assert property (@(posedge clock) disable iff (rst)
    reg_wr && reg_addr == BUF_ADDR && !buf_open && !rise_evt |=>
    $stable(serial_shift_buffer))
  else $error("buffer written while closed");
endmodule : ssio_core
`default_nettype wire

// >>> ssio_pkg.sv
`default_nettype none
package ssio_pkg;
  localparam int unsigned ADDR_W        = 12;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned FIFO_DEPTH    = 8;
  localparam logic [11:0] MODE_LO_ADDR  = 12'hFE0;
  localparam logic [11:0] MODE_HI_ADDR  = 12'hFE1;
  localparam logic [11:0] BUF_ADDR      = 12'hFE4;
  localparam int unsigned ORDER_BIT     = 0;
  localparam int unsigned DIR_BIT       = 1;
  localparam int unsigned ENABLE_BIT    = 2;
  localparam int unsigned START_BIT     = 3;
  localparam int unsigned UNUSED_BIT    = 4;
  localparam int unsigned CSEL_LSB      = 5;
  localparam logic [1:0]  START_SEL     = 2'h3;
  localparam logic [7:0]  MODE_RESET    = 8'h00;
  localparam logic [2:0]  CSEL_EXT      = 3'h0;
  localparam logic [2:0]  CSEL_TIMER    = 3'h1;
  localparam logic [1:0]  CSEL_CPU_TOP  = 2'h1;
  localparam logic [2:0]  CSEL_SLOW     = 3'h4;
  localparam logic [2:0]  CSEL_FAST     = 3'h7;
  localparam logic [1:0]  CPU_DIV4      = 2'h0;
  localparam logic [1:0]  CPU_DIV8      = 2'h1;
  localparam logic [1:0]  CPU_DIV64     = 2'h2;
  localparam int unsigned HALF_W        = 9;
  // half periods of the serial clock, in system clocks
  localparam logic [8:0]  HALF_DIV4     = 9'h002;
  localparam logic [8:0]  HALF_DIV8     = 9'h004;
  localparam logic [8:0]  HALF_DIV64    = 9'h020;
  localparam logic [8:0]  HALF_SLOW     = 9'h200;
  localparam logic [8:0]  HALF_FAST     = 9'h008;
  localparam logic [2:0]  LAST_BIT      = 3'h7;
  typedef enum logic [2:0] {
    SSIO_SRC_EXT, SSIO_SRC_TIMER, SSIO_SRC_CPU,
    SSIO_SRC_SLOW, SSIO_SRC_FAST, SSIO_SRC_NONE
  } ssio_src_e;
  typedef enum logic {SSIO_IDLE, SSIO_RUN} ssio_state_e;
endpackage : ssio_pkg
`default_nettype wire

// >>> ssio_fifo_if.sv
`default_nettype none
interface ssio_fifo_if #(parameter int unsigned WIDTH = 8);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;
  modport fifo (input in_valid, in_data, out_ready,
                output in_ready, out_valid, out_data);
  modport core (output in_valid, in_data, out_ready,
                input in_ready, out_valid, out_data);
endinterface : ssio_fifo_if
`default_nettype wire

// >>> ssio_fifo.sv
`default_nettype none
module ssio_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic clock,
  input  wire logic rst,
  ssio_fifo_if.fifo f
);
  import ssio_pkg::*;
  localparam int unsigned PW = $clog2(DEPTH);
  generate
    if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1)
    begin : g_bad
      $error("fifo depth must be a power of two of at least 2");
    end
  endgenerate
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  logic             push;
  logic             pop;
  assign f.in_ready  = (count_reg != (PW+1)'(DEPTH));
  assign f.out_valid = (count_reg != '0);
  assign f.out_data  = mem[rd_ptr_reg];
  assign push = f.in_valid & f.in_ready;
  assign pop  = f.out_valid & f.out_ready;
  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= f.in_data;
    end
  end
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + PW'(1);
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + PW'(1);
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + (PW+1)'(1);
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - (PW+1)'(1);
      end
    end
  end
  a_fifo_bound: assert property (@(posedge clock) disable iff (rst)
    count_reg <= (PW+1)'(DEPTH))
  else $error("fifo count above depth");
endmodule : ssio_fifo
`default_nettype wire

// >>> ssio_partner.sv
`default_nettype none
// far-side serial device: shifts data on falling edges, captures on rising
module ssio_partner
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       load,
  input  wire logic [7:0] tx_byte,
  input  wire logic       lsb_first,
  input  wire logic       ext_go,
  input  wire logic       sck_line,
  input  wire logic       so_line,
  output logic            sck_drive,
  output logic            si_out,
  output logic [7:0]      cap_byte,
  output logic [3:0]      cap_count
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [4:0] HALF_M1 = 5'h07;
  logic       sck_prev;
  logic [2:0] bit_idx;
  logic [4:0] half_cnt;
  logic [4:0] edge_cnt;

  always_ff @(posedge clock)
  begin
    sck_prev <= sck_line;
    if (rst || load)
    begin
      bit_idx   <= 3'h0;
      cap_count <= 4'h0;
      si_out    <= lsb_first ? !tx_byte[0] : !tx_byte[7];
    end
    else if (sck_prev && !sck_line)
    begin
      si_out  <= lsb_first ? tx_byte[bit_idx] : tx_byte[3'h7 - bit_idx];
      bit_idx <= bit_idx + 3'h1;
    end
    else if (!sck_prev && sck_line)
    begin
      cap_byte  <= lsb_first ? {so_line, cap_byte[7:1]}
                             : {cap_byte[6:0], so_line};
      cap_count <= cap_count + 4'h1;
      // data line no longer holds its last bit once the byte is done
      if (cap_count == 4'h7)
        si_out <= !si_out;
    end
  end

  // external clock: eight low/high periods, idle high
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      edge_cnt  <= 5'h00;
      half_cnt  <= 5'h00;
      sck_drive <= 1'b1;
    end
    else if (ext_go && edge_cnt == 5'h00)
    begin
      edge_cnt  <= 5'h10;
      half_cnt  <= HALF_M1;
      sck_drive <= 1'b0;
    end
    else if (edge_cnt != 5'h00)
    begin
      half_cnt <= (half_cnt == 5'h00) ? HALF_M1 : half_cnt - 5'h01;
      if (half_cnt == 5'h00)
      begin
        edge_cnt <= edge_cnt - 5'h01;
        if (edge_cnt != 5'h01)
          sck_drive <= !sck_drive;
      end
    end
  end
endmodule : ssio_partner
`default_nettype wire

// >>> ssio_core_test.sv
`default_nettype none
module ssio_core_test;
  timeunit 1ns;
  timeprecision 1ns;
  import ssio_pkg::*;
  typedef struct packed {logic [7:0] mode; logic [1:0] div;
                         logic [7:0] si; logic [7:0] tx;} ssio_row_s;
  ssio_row_s rows [8] = '{
    '{8'hEE, 2'h0, 8'hA5, 8'h48}, '{8'h8F, 2'h0, 8'h5A, 8'h81},
    '{8'h4E, 2'h3, 8'hC3, 8'h17}, '{8'h6F, 2'h2, 8'h96, 8'hE2},
    '{8'h4C, 2'h2, 8'h0F, 8'h7E}, '{8'h2E, 2'h0, 8'h69, 8'hB4},
    '{8'h0E, 2'h0, 8'h1E, 8'hD2}, '{8'h0D, 2'h0, 8'hF0, 8'h35}};
  logic        clock, rst, reg_wr, reg_bit_wr, reg_rd, reg_refused;
  logic        timer_out_clock, serial_irq_enable, irq_flag_clr, rx_ready;
  logic        sck_out, sck_oe_n, so_out, so_oe_n, serial_irq_flag;
  logic        serial_irq, busy, rx_valid, p_load, p_lsb, p_go, p_sck, p_si;
  logic        ref_v;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, rx_data, p_tx, p_cap, rd_v;
  logic [1:0]  cpu_div_sel;
  logic [3:0]  p_count;
  ssio_row_s   r;
  int          i, cyc, bad_count, cmp_count;
  wire         sck_line = !sck_oe_n ? sck_out : p_sck;
  // data output has a pull-up when released
  wire         so_line = !so_oe_n ? so_out : 1'b1;

  ssio_core u_ssio_core (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_bit_wr(reg_bit_wr),
    .reg_bit_sel(2'h3), .reg_bit_val(1'b1), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_refused(reg_refused),
    .cpu_div_sel(cpu_div_sel), .timer_out_clock(timer_out_clock),
    .sck_in(sck_line), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
    .si_in(p_si), .so_out(so_out), .so_oe_n(so_oe_n),
    .serial_irq_enable(serial_irq_enable), .irq_flag_clr(irq_flag_clr),
    .serial_irq_flag(serial_irq_flag), .serial_irq(serial_irq),
    .busy(busy), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready));
  ssio_partner u_ssio_partner (.clock(clock), .rst(rst), .load(p_load),
    .tx_byte(p_tx), .lsb_first(p_lsb), .ext_go(p_go), .sck_line(sck_line),
    .so_line(so_line), .sck_drive(p_sck), .si_out(p_si), .cap_byte(p_cap),
    .cap_count(p_count));

  task automatic give_verdict;
  begin
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask : give_verdict

  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
  begin
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  end
  endtask : chk

  // kind 0 byte write, 1 read, 2 start-bit write
  task automatic acc(input int kind, input logic [11:0] a,
                     input logic [7:0] d);
  begin
    @(posedge clock);
    p_load     <= 1'b0;
    reg_addr   <= a;
    reg_wdata  <= d;
    reg_wr     <= (kind == 0);
    reg_rd     <= (kind == 1);
    reg_bit_wr <= (kind == 2);
    @(posedge clock);
    reg_wr     <= 1'b0;
    reg_rd     <= 1'b0;
    reg_bit_wr <= 1'b0;
    #1;
    rd_v  = reg_rdata;
    ref_v = reg_refused;
  end
  endtask : acc

  // 0 flag set, 1 busy, 2 serial clock low, 3 byte waiting
  task automatic wait_for(input int what);
    int n;
  begin
    for (n = 0; n < 10000; n++)
    begin
      @(posedge clock);
      #1;
      if ((what == 0 && serial_irq_flag === 1'b1) ||
          (what == 1 && busy === 1'b1) || (what == 2 && sck_out === 1'b0) ||
          (what == 3 && rx_valid === 1'b1))
        break;
    end
    chk("wait", {7'h00, n == 10000}, 8'h00);
  end
  endtask : wait_for

  task automatic pop(input logic [7:0] e);
  begin
    wait_for(3);
    chk("rx_data", rx_data, e);
    @(posedge clock);
    rx_ready <= 1'b1;
    @(posedge clock);
    rx_ready <= 1'b0;
  end
  endtask : pop

  task automatic load_far(input logic [7:0] b, input logic lsb);
  begin
    @(posedge clock);
    p_tx   <= b;
    p_lsb  <= lsb;
    p_load <= 1'b1;
  end
  endtask : load_far

  initial
  begin
    clock = 1'b0;
    forever #50 clock = !clock;
  end

  always @(posedge clock)
  begin
    cyc++;
    if (cyc[2:0] == 3'h0)
      timer_out_clock <= !timer_out_clock;
    if (cyc == 30000)
    begin
      bad_count++;
      give_verdict();
    end
  end

  initial
  begin
    {rst, p_load} = 2'h3;
    {reg_wr, reg_bit_wr, reg_rd, timer_out_clock, irq_flag_clr} = 5'h00;
    {serial_irq_enable, rx_ready, p_go, p_lsb} = 4'h0;
    {reg_addr, reg_wdata, p_tx, cpu_div_sel} = 30'h0000_0000;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    #1;
    chk("reset", {1'b0, serial_irq_flag, busy, rx_valid, sck_oe_n, sck_out,
        so_oe_n, so_out}, 8'h0F);
    chk("rdata", reg_rdata, 8'h00);
    acc(1, MODE_LO_ADDR, 8'h00);
    chk("mode_read", rd_v, 8'h00);
    acc(0, MODE_HI_ADDR, 8'h0E);
    chk("hi_refused", {7'h00, ref_v}, 8'h01);
    $display("test reset and mode access done");
    for (i = 0; i < 8; i++)
    begin
      r = rows[i];
      @(posedge clock);
      cpu_div_sel       <= r.div;
      serial_irq_enable <= i[0];
      load_far(r.si, r.mode[0]);
      acc(0, MODE_LO_ADDR, r.mode & 8'hF7);
      acc(0, BUF_ADDR, r.tx);
      acc(i[0] ? 2 : 0, MODE_LO_ADDR, r.mode);
      if (r.mode[7:5] == CSEL_EXT)
      begin
        wait_for(1);
        @(posedge clock);
        p_go <= 1'b1;
        @(posedge clock);
        p_go <= 1'b0;
      end
      wait_for(0);
      chk("flag", {5'h00, serial_irq_flag, busy, serial_irq},
          {6'h02, i[0]});
      acc(1, BUF_ADDR, 8'h00);
      chk("rx_byte", rd_v, r.si);
      chk("pulses", {4'h0, p_count}, 8'h08);
      chk("tx_byte", p_cap, r.mode[1] ? r.tx : 8'hFF);
      @(posedge clock);
      irq_flag_clr <= 1'b1;
      @(posedge clock);
      irq_flag_clr <= 1'b0;
      #1;
      chk("flag_clr", {7'h00, serial_irq_flag}, 8'h00);
      $display("test row %0d done", i);
    end
    load_far(8'h3C, 1'b0);
    acc(0, MODE_LO_ADDR, 8'hEE);
    repeat (40) @(posedge clock);
    #1;
    chk("held", {6'h00, busy, rx_valid}, 8'h01);
    for (i = 0; i < 8; i++)
      pop(rows[i].si);
    wait_for(0);
    pop(8'h3C);
    #1;
    chk("empty", {7'h00, rx_valid}, 8'h00);
    $display("test receive buffer done");
    acc(0, MODE_LO_ADDR, 8'hEA);
    repeat (30) @(posedge clock);
    #1;
    chk("no_enable", {4'h0, busy, serial_irq_flag, sck_oe_n, sck_out},
        8'h01);
    rx_ready <= 1'b1;
    for (i = 0; i < 3; i++)
    begin
      @(posedge clock);
      cpu_div_sel <= (i == 2) ? CPU_DIV8 : CPU_DIV4;
      acc(0, MODE_LO_ADDR, i ? 8'h4E : 8'hEE);
      wait_for(2);
      chk("running", {6'h00, busy, serial_irq_flag}, 8'h02);
      acc(1, BUF_ADDR, 8'h00);
      chk("buf_refused", {7'h00, ref_v}, i ? 8'h00 : 8'h01);
      wait_for(0);
    end
    $display("test buffer access done");
    @(posedge clock);
    cpu_div_sel <= CPU_DIV64;
    acc(0, MODE_LO_ADDR, 8'hEE);
    repeat (300) @(posedge clock);
    #1;
    chk("stall", {6'h00, busy, serial_irq_flag}, 8'h02);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    #1;
    chk("re_reset", {6'h00, busy, sck_oe_n}, 8'h01);
    $display("test stall and reset done");
    give_verdict();
  end
endmodule : ssio_core_test
`default_nettype wire
